//--- rtl/rtc_trim_hw_watchdog.sv
// What this block does
// - the 32768 Hz tick is divided down into a time mark every half second.
// - with the slow oscillator disabled the tick comes from the fast clock divided by 2930.
// - the 32-bit counter steps every second (0x), half second (10) or two seconds (11).
// - each counter step adds the trim magnitude into a 24-bit accumulator.
// - trim is sign-magnitude; an accumulator overflow adds one count if positive, drops one if negative.
// - the periodic interrupt interval is 1 s (0xx), 0.5 s, 2 s, 4 s or 8 s (100..111).
// - a set load bit moves staged count, accumulator and trim into live state on the next slow tick.
// - an interval interrupt not serviced within half a second causes a full chip reset.
// - the interval interrupt is routed onto the shared external interrupt 5 line.
// - the watchdog runs only while the clock interrupt enable is set.
// - the clock interrupt flag sets on each interval and clears when the source register is read.
// - staging registers hold the count in four bytes and accumulator and trim in three each.
// - the source register also holds bus and keypad enable/flag pairs and the power-down mux bit.
`timescale 1ns/1ps
`default_nettype none
module rtc_trim_hw_watchdog
  import rtw_pkg::*;
#(
  parameter int HALF_TICKS = RTW_HALF_TICKS,
  parameter int WDOG_TICKS = RTW_WDOG_TICKS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        osc32k,
  input  wire logic        busIrqEvt,
  input  wire logic        keypadIrqEvt,
  output var  logic        irq5,
  output var  logic        irqOut,
  output var  logic        chipResetReq,
  output var  logic        powerdownMux
);
  rtw_bus_t         busSt_q;
  logic [7:0]       ctrl_q;
  logic [7:0]       int5_q;
  logic [7:0]       stage_q [RTW_STAGE_BYTES];
  logic             oscOff_q;
  logic [RTW_ST_W-1:0] stat_q;
  logic [RTW_ST_W-1:0] mask_q;
  logic             oscPrev_q;
  logic [11:0]      fastCnt_q;
  logic [15:0]      halfCnt_q;
  logic [3:0]       markCnt_q;
  logic [31:0]      cnt_q;
  logic [23:0]      acc_q;
  logic [23:0]      trim_q;
  logic [15:0]      wdCnt_q;

  logic        accept;
  logic        wrAcc;
  logic        rdAcc;
  logic        fastTick;
  logic        tick32;
  logic        halfMark;
  logic        countTick;
  logic        ivalTick;
  logic        loadNow;
  logic [24:0] accSum;
  logic        carry;
  logic        wdExpire;
  logic        rdInt5;
  logic [79:0] liveVec;
  logic [79:0] stageVec;
  logic [7:0]  rdMux;

  // bus handshake: one wait cycle, then the answer
  assign accept = (avs_read || avs_write) && !avs_waitrequest;
  assign wrAcc  = accept && avs_write && avs_byteenable[0];
  assign rdAcc  = accept && avs_read;
  assign rdInt5 = rdAcc && (avs_address == RTW_INT5_ADDR);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busSt_q         <= RTW_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (busSt_q)
        RTW_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            busSt_q         <= RTW_BUS_ANS;
            avs_waitrequest <= 1'b0;
          end
        end
        RTW_BUS_ANS: begin
          busSt_q         <= RTW_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          busSt_q         <= RTW_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  assign liveVec  = {trim_q, acc_q, cnt_q};
  genvar gi;
  generate
    for (gi = 0; gi < RTW_STAGE_BYTES; gi++) begin : g_stage
      assign stageVec[gi*8 +: 8] = stage_q[gi];
      // staged bytes, count lowest, most significant byte highest
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          stage_q[gi] <= 8'h00;
        end else if (wrAcc && avs_address == RTW_STAGE_ADDR + 16'(gi * 4)) begin
          stage_q[gi] <= avs_writedata[7:0];
        end
      end
    end
  endgenerate

  // read mux; staged addresses show the live state
  always_comb begin
    rdMux = 8'h00;
    if (avs_address == RTW_INT5_ADDR) begin
      rdMux = int5_q;
    end else if (avs_address == RTW_CTRL_ADDR) begin
      rdMux = ctrl_q;
    end else if (avs_address == RTW_STAT_ADDR) begin
      rdMux = 8'(stat_q);
    end else if (avs_address == RTW_MASK_ADDR) begin
      rdMux = 8'(mask_q);
    end else if (avs_address == RTW_OSC_ADDR) begin
      rdMux = {7'h00, oscOff_q};
    end else begin
      for (int i = 0; i < RTW_STAGE_BYTES; i++) begin
        if (avs_address == RTW_STAGE_ADDR + 16'(i * 4)) begin
          rdMux = liveVec[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (busSt_q == RTW_BUS_IDLE && avs_read) begin
      avs_readdata <= {24'h00_0000, rdMux};
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= RTW_CTRL_RST;
      mask_q   <= '0;
      oscOff_q <= 1'b0;
    end else begin
      if (wrAcc && avs_address == RTW_CTRL_ADDR) begin
        ctrl_q <= {2'b00, avs_writedata[5:0]};
      end else if (loadNow) begin
        ctrl_q[RTW_CTL_LOAD] <= 1'b0;
      end
      if (wrAcc && avs_address == RTW_MASK_ADDR) begin
        mask_q <= avs_writedata[RTW_ST_W-1:0];
      end
      if (wrAcc && avs_address == RTW_OSC_ADDR) begin
        oscOff_q <= avs_writedata[0];
      end
    end
  end

  // clock source and half-second marks
  assign fastTick = (fastCnt_q == 12'(RTW_MCLK_DIV - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev_q <= 1'b0;
      fastCnt_q <= 12'h000;
    end else begin
      oscPrev_q <= osc32k;
      fastCnt_q <= fastTick ? 12'h000 : fastCnt_q + 12'h001;
    end
  end
  assign tick32   = oscOff_q ? fastTick : (osc32k && !oscPrev_q);
  assign halfMark = tick32 && (halfCnt_q == 16'(HALF_TICKS - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_q <= 16'h0000;
      markCnt_q <= 4'h0;
    end else if (tick32) begin
      halfCnt_q <= halfMark ? 16'h0000 : halfCnt_q + 16'h0001;
      if (halfMark) begin
        markCnt_q <= markCnt_q + 4'h1;
      end
    end
  end

  // count rate and interrupt interval from the mark counter
  always_comb begin
    case (ctrl_q[RTW_CTL_CSEL +: 2])
      2'b10:   countTick = halfMark;
      2'b11:   countTick = halfMark && (markCnt_q[1:0] == 2'b11);
      default: countTick = halfMark && markCnt_q[0];
    endcase
    case (ctrl_q[RTW_CTL_IVAL +: 3])
      3'b100:  ivalTick = halfMark;
      3'b101:  ivalTick = halfMark && (markCnt_q[1:0] == 2'b11);
      3'b110:  ivalTick = halfMark && (markCnt_q[2:0] == 3'b111);
      3'b111:  ivalTick = halfMark && (markCnt_q == 4'hf);
      default: ivalTick = halfMark && markCnt_q[0];
    endcase
  end

  // live time state
  assign loadNow = tick32 && ctrl_q[RTW_CTL_LOAD];
  assign accSum  = {1'b0, acc_q} + {2'b00, trim_q[22:0]};
  assign carry   = accSum[24];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 32'h0000_0000;
      acc_q  <= 24'h00_0000;
      trim_q <= 24'h00_0000;
    end else if (loadNow) begin
      cnt_q  <= stageVec[31:0];
      acc_q  <= stageVec[55:32];
      trim_q <= stageVec[79:56];
    end else if (countTick) begin
      acc_q <= accSum[23:0];
      if (!carry) begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end else if (!trim_q[23]) begin
        cnt_q <= cnt_q + 32'h0000_0002;
      end
    end
  end

  // irq5 source register; set wins over clear-on-read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int5_q <= RTW_INT5_RST;
    end else begin
      if (wrAcc && avs_address == RTW_INT5_ADDR) begin
        int5_q[RTW_I5_POWERDOWN_MUX_CTL] <= avs_writedata[RTW_I5_POWERDOWN_MUX_CTL];
        int5_q[RTW_I5_RIEN]  <= avs_writedata[RTW_I5_RIEN];
        int5_q[RTW_I5_BIEN]  <= avs_writedata[RTW_I5_BIEN];
        int5_q[RTW_I5_KIEN]  <= avs_writedata[RTW_I5_KIEN];
      end
      if (ivalTick) begin
        int5_q[RTW_I5_RFLAG] <= 1'b1;
      end else if (rdInt5 && avs_readdata[RTW_I5_RFLAG]) begin
        int5_q[RTW_I5_RFLAG] <= 1'b0;
      end
      if (busIrqEvt) begin
        int5_q[RTW_I5_BFLAG] <= 1'b1;
      end else if (rdInt5 && avs_readdata[RTW_I5_BFLAG]) begin
        int5_q[RTW_I5_BFLAG] <= 1'b0;
      end
      if (keypadIrqEvt) begin
        int5_q[RTW_I5_KFLAG] <= 1'b1;
      end else if (rdInt5 && avs_readdata[RTW_I5_KFLAG]) begin
        int5_q[RTW_I5_KFLAG] <= 1'b0;
      end
    end
  end

  // watchdog on a pending, enabled clock interrupt
  assign wdExpire = tick32 && int5_q[RTW_I5_RIEN] && int5_q[RTW_I5_RFLAG]
                    && (wdCnt_q == 16'(WDOG_TICKS - 1));
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdCnt_q      <= 16'h0000;
      chipResetReq <= 1'b0;
    end else begin
      chipResetReq <= wdExpire;
      if (!int5_q[RTW_I5_RIEN] || !int5_q[RTW_I5_RFLAG] || wdExpire) begin
        wdCnt_q <= 16'h0000;
      end else if (tick32) begin
        wdCnt_q <= wdCnt_q + 16'h0001;
      end
    end
  end

  // outputs, event status and interrupt
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq5         <= 1'b0;
      irqOut       <= 1'b0;
      powerdownMux <= 1'b0;
      stat_q       <= '0;
    end else begin
      irq5 <= (int5_q[RTW_I5_RIEN] && int5_q[RTW_I5_RFLAG])
              || (int5_q[RTW_I5_BIEN] && int5_q[RTW_I5_BFLAG])
              || (int5_q[RTW_I5_KIEN] && int5_q[RTW_I5_KFLAG]);
      irqOut       <= |(stat_q & mask_q);
      powerdownMux <= int5_q[RTW_I5_POWERDOWN_MUX_CTL];
      for (int i = 0; i < RTW_ST_W; i++) begin
        if (wrAcc && avs_address == RTW_STAT_ADDR && avs_writedata[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
      if (ivalTick) begin
        stat_q[RTW_ST_IVAL] <= 1'b1;
      end
      if (countTick && carry && !loadNow) begin
        stat_q[RTW_ST_TRIM] <= 1'b1;
      end
      if (wdExpire) begin
        stat_q[RTW_ST_WDOG] <= 1'b1;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  half_mark_a: assert property (halfMark |-> tick32 && halfCnt_q == 16'(HALF_TICKS - 1)
    ##1 halfCnt_q == 16'h0000) else $error("half mark off its count");
  fast_div_a: assert property (oscOff_q && tick32 |=> fastCnt_q == 12'h000)
    else $error("fallback divider did not restart");
  count_step_a: assert property (countTick && !loadNow && !carry
    |=> cnt_q == $past(cnt_q) + 32'h0000_0001) else $error("counter did not step by one");
  accum_a: assert property (countTick && !loadNow
    |=> acc_q == $past(accSum[23:0])) else $error("accumulator did not add trim");
  trim_neg_a: assert property (countTick && !loadNow && carry && trim_q[23]
    |=> cnt_q == $past(cnt_q)) else $error("negative trim did not suppress a count");
  ival_flag_a: assert property (ivalTick |=> int5_q[RTW_I5_RFLAG] && stat_q[RTW_ST_IVAL])
    else $error("interval event lost");
  load_live_a: assert property (loadNow |=> cnt_q == $past(stageVec[31:0])
    && trim_q == $past(stageVec[79:56]) && !ctrl_q[RTW_CTL_LOAD]) else $error("load failed");
  wdog_fire_a: assert property (wdExpire |=> chipResetReq ##1 !chipResetReq)
    else $error("watchdog reset pulse wrong");
  irq5_route_a: assert property (int5_q[RTW_I5_RIEN] && int5_q[RTW_I5_RFLAG] |=> irq5)
    else $error("clock interrupt not on line 5");
  wdog_off_a: assert property (!int5_q[RTW_I5_RIEN] |=> !chipResetReq && wdCnt_q == 16'h0000)
    else $error("watchdog active while disabled");
  rd_clear_a: assert property (rdInt5 && avs_readdata[RTW_I5_RFLAG] && !ivalTick
    |=> !int5_q[RTW_I5_RFLAG]) else $error("read did not clear clock flag");

  load_seen_c: cover property (loadNow);
  trim_carry_c: cover property (countTick && carry);
  wdog_reset_c: cover property (chipResetReq);
  read_clear_c: cover property (rdInt5 && avs_readdata[RTW_I5_RFLAG]);
endmodule : rtc_trim_hw_watchdog
`default_nettype wire

//--- rtl/rtw_pkg.sv
package rtw_pkg;
  // register byte addresses
  localparam logic [15:0] RTW_INT5_ADDR   = 16'hff94;
  localparam logic [15:0] RTW_CTRL_ADDR   = 16'hffb0;
  localparam logic [15:0] RTW_STAGE_ADDR  = 16'hffb4;  // 10 words: count 0..3, accum 0..2, trim 0..2
  localparam logic [15:0] RTW_STAT_ADDR   = 16'hffdc;
  localparam logic [15:0] RTW_MASK_ADDR   = 16'hffe0;
  localparam logic [15:0] RTW_OSC_ADDR    = 16'hffe4;
  localparam int          RTW_STAGE_BYTES = 10;
  // control register fields
  localparam int RTW_CTL_LOAD  = 5;
  localparam int RTW_CTL_CSEL  = 3;  // two bits 4:3
  localparam int RTW_CTL_IVAL  = 0;  // three bits 2:0
  // irq5 source control fields
  localparam int RTW_I5_POWERDOWN_MUX_CTL  = 7;
  localparam int RTW_I5_RIEN   = 5;
  localparam int RTW_I5_RFLAG  = 4;
  localparam int RTW_I5_BIEN   = 3;
  localparam int RTW_I5_BFLAG  = 2;
  localparam int RTW_I5_KIEN   = 1;
  localparam int RTW_I5_KFLAG  = 0;
  // status / mask bits
  localparam int RTW_ST_IVAL   = 0;
  localparam int RTW_ST_TRIM   = 1;
  localparam int RTW_ST_WDOG   = 2;
  localparam int RTW_ST_W      = 3;
  // reset values
  localparam logic [7:0] RTW_CTRL_RST = 8'h00;
  localparam logic [7:0] RTW_INT5_RST = 8'h00;
  // timing
  localparam int RTW_SLOW_HZ      = 32768;
  localparam int RTW_HALF_SEC_MS  = 500;
  localparam int RTW_HALF_TICKS   = RTW_SLOW_HZ * RTW_HALF_SEC_MS / 1000;
  localparam int RTW_WDOG_MS      = 500;
  localparam int RTW_WDOG_TICKS   = RTW_SLOW_HZ * RTW_WDOG_MS / 1000;
  localparam int RTW_MCLK_DIV     = 2930;
  typedef enum logic [0:0] {
    RTW_BUS_IDLE = 1'b0,
    RTW_BUS_ANS  = 1'b1
  } rtw_bus_t;
endpackage : rtw_pkg

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtw_pkg::*;
  localparam int HT = 8;
  localparam int WT = 20;
  localparam int MK = HT * 8;
  logic        clk_sys, rst_n, avs_read, avs_write, osc32k, busIrqEvt, keypadIrqEvt;
  logic        avs_waitrequest, irq5, irqOut, chipResetReq, powerdownMux;
  logic [15:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d;
  logic [3:0]  avs_byteenable;
  logic [2:0]  oscCnt = 3'd0;
  logic [7:0]  dc, da;
  int          cyc, miscompares, comparisons, resets, p, r, i;
  int          steps [4] = '{8, 8, 16, 4};
  int          codes [5] = '{0, 4, 5, 6, 7};
  int          marks [5] = '{2, 1, 4, 8, 16};

  rtc_trim_hw_watchdog #(.HALF_TICKS(HT), .WDOG_TICKS(WT)) rtc_trim_hw_watchdog_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .osc32k(osc32k),
    .busIrqEvt(busIrqEvt), .keypadIrqEvt(keypadIrqEvt), .irq5(irq5), .irqOut(irqOut),
    .chipResetReq(chipResetReq), .powerdownMux(powerdownMux));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // slow oscillator at one eighth of the system clock, plus counters
  always @(posedge clk_sys) begin
    oscCnt <= oscCnt + 3'd1;
    osc32k <= oscCnt[2];
    cyc    <= cyc + 1;
    if (chipResetReq === 1'b1) resets <= resets + 1;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] v,
                      output logic [31:0] q);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= {24'h00_0000, v};
    avs_write     <= w;
    avs_read      <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : xfer

  task automatic ld(input logic [31:0] c, input logic [23:0] ac, input logic [23:0] tr,
                    input logic [1:0] cs);
    logic [79:0] b;
    int          k;
    b = {tr, ac, c};
    for (k = 0; k < RTW_STAGE_BYTES; k++) xfer(1, RTW_STAGE_ADDR + 16'(4 * k), b[8*k +: 8], d);
    xfer(1, RTW_CTRL_ADDR, {2'b00, 1'b1, cs, 3'b100}, d);
    k = 0;
    d = 32'h0000_00ff;
    while (d[RTW_CTL_LOAD] !== 1'b0 && k < 20) begin
      xfer(0, RTW_CTRL_ADDR, 8'h00, d);
      k++;
    end
  endtask : ld

  // count and accumulator byte0 deltas over sixteen half marks
  task automatic window(output logic [7:0] c, output logic [7:0] a);
    int          t0;
    logic [31:0] c0, a0;
    t0 = cyc;
    xfer(0, RTW_STAGE_ADDR, 8'h00, c0);
    xfer(0, RTW_STAGE_ADDR + 16'd16, 8'h00, a0);
    while (cyc < t0 + 16 * MK) @(posedge clk_sys);
    xfer(0, RTW_STAGE_ADDR, 8'h00, d);
    c = d[7:0] - c0[7:0];
    xfer(0, RTW_STAGE_ADDR + 16'd16, 8'h00, d);
    a = d[7:0] - a0[7:0];
  endtask : window

  task automatic waitHi(input int lim, output int t);
    int n;
    n = 0;
    repeat (3) @(posedge clk_sys);
    while (irqOut !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) miscompares++;
    t = cyc;
  endtask : waitHi

  // spacing of two interval events seen on irqOut
  task automatic period(input int lim, output int q);
    int t1, t2;
    xfer(1, RTW_STAT_ADDR, 8'h01, d);
    waitHi(lim, t1);
    xfer(1, RTW_STAT_ADDR, 8'h01, d);
    waitHi(lim, t2);
    q = t2 - t1;
  endtask : period

  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (90000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 16'h0000;
    avs_writedata = 32'h0000_0000; avs_byteenable = 4'h1;
    busIrqEvt = 1'b0; keypadIrqEvt = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    xfer(0, RTW_CTRL_ADDR, 8'h00, d);
    chk("rtcControl", {24'h0, RTW_CTRL_RST}, d);
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    chk("irq5Control", {24'h0, RTW_INT5_RST}, d);
    xfer(0, 16'h0000, 8'h00, d);
    chk("unmapped", 32'h0000_0000, d);
    avs_byteenable <= 4'h0;
    xfer(1, RTW_MASK_ADDR, 8'h07, d);
    avs_byteenable <= 4'h1;
    xfer(0, RTW_MASK_ADDR, 8'h00, d);
    chk("maskNoByteEn", 32'h0000_0000, d);
    $display("test reset done");
    ld(32'h1122_3344, 24'h55_6677, 24'h00_0000, 2'b11);
    chk("loadBit", 32'h0000_0000, {26'h0, d[5:0]} & 32'h0000_0020);
    for (i = 1; i < RTW_STAGE_BYTES; i++) begin
      xfer(0, RTW_STAGE_ADDR + 16'(4 * i), 8'h00, d);
      chk("stageByte", {24'h0, 8'(80'h0000_0055_6677_1122_3344 >> (8 * i))}, d);
    end
    $display("test load done");
    for (i = 0; i < 4; i++) begin
      ld(32'h0, 24'h0, 24'h0, 2'(i));
      window(dc, da);
      chk("countSteps", 32'(steps[i]), {24'h0, dc});
    end
    $display("test rate done");
    ld(32'h0, 24'hFF_F900, 24'h00_06FD, 2'b10);
    window(dc, da);
    chk("countPlus", 32'd17, {24'h0, dc});
    chk("accumStep", 32'h0000_00D0, {24'h0, da});
    xfer(0, RTW_STAT_ADDR, 8'h00, d);
    chk("trimEvent", 32'h1, 32'(d[RTW_ST_TRIM]));
    ld(32'h0, 24'hFF_F900, 24'h80_06FD, 2'b10);
    window(dc, da);
    chk("countMinus", 32'd15, {24'h0, dc});
    $display("test trim done");
    xfer(1, RTW_MASK_ADDR, 8'h01, d);
    for (i = 0; i < 5; i++) begin
      xfer(1, RTW_CTRL_ADDR, 8'(codes[i]), d);
      period(2000, p);
      chk("ivalPeriod", 32'(marks[i] * MK), 32'(p));
    end
    xfer(0, RTW_STAT_ADDR, 8'h00, d);
    chk("ivalSticky", 32'h1, 32'(d[RTW_ST_IVAL]));
    xfer(1, RTW_MASK_ADDR, 8'h00, d);
    repeat (2) @(posedge clk_sys);
    chk("irqMasked", 32'h0, 32'(irqOut));
    $display("test interval done");
    xfer(1, RTW_CTRL_ADDR, 8'h04, d);
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    xfer(1, RTW_INT5_ADDR, 8'h20, d);
    for (i = 0; i < 200 && irq5 !== 1'b1; i++) @(posedge clk_sys);
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    chk("clockFlagSet", 32'h30, d);
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    chk("clockFlagClr", 32'h20, d);
    repeat (2) @(posedge clk_sys);
    chk("irq5Low", 32'h0, 32'(irq5));
    r = resets;
    repeat (10) begin
      repeat (90) @(posedge clk_sys);
      xfer(0, RTW_INT5_ADDR, 8'h00, d);
    end
    chk("wdogServiced", 32'(r), 32'(resets));
    repeat (400) @(posedge clk_sys);
    chk("wdogFired", 32'h1, 32'(resets != r));
    xfer(0, RTW_STAT_ADDR, 8'h00, d);
    chk("wdogStatus", 32'h1, 32'(d[RTW_ST_WDOG]));
    xfer(1, RTW_INT5_ADDR, 8'h00, d);
    repeat (2) @(posedge clk_sys);
    r = resets;
    repeat (600) @(posedge clk_sys);
    chk("wdogOff", 32'(r), 32'(resets));
    $display("test watchdog done");
    busIrqEvt <= 1'b1;
    keypadIrqEvt <= 1'b1;
    @(posedge clk_sys);
    busIrqEvt <= 1'b0;
    keypadIrqEvt <= 1'b0;
    xfer(1, RTW_INT5_ADDR, 8'h8A, d);
    repeat (3) @(posedge clk_sys);
    chk("irq5Shared", 32'h1, 32'(irq5));
    chk("powerdown_mux_ctl", 32'h1, 32'(powerdownMux));
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    chk("srcFlags", 32'h8F, d & 32'hEF);
    xfer(0, RTW_INT5_ADDR, 8'h00, d);
    chk("srcCleared", 32'h8A, d & 32'hEF);
    $display("test sources done");
    xfer(1, RTW_OSC_ADDR, 8'h01, d);
    xfer(1, RTW_MASK_ADDR, 8'h01, d);
    period(30000, p);
    chk("fastPeriod", 32'(HT * RTW_MCLK_DIV), 32'(p));
    $display("test fast clock done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
